/* File: logic/bwdc_pkg.sv */
package bwdc_pkg;

   // ***************************************************************
   // register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [7:0] IDX_CLASS_CODE = 8'h09;
   localparam logic [7:0] IDX_WIN0_BASE = 8'h44;
   localparam logic [7:0] IDX_WIN0_LIMIT = 8'h48;
   localparam logic [7:0] IDX_WIN1_BASE = 8'h4C;
   localparam logic [7:0] IDX_WIN1_LIMIT = 8'h50;
   localparam logic [7:0] IDX_EXT_WINDOW_ENABLE = 8'h54;
   localparam logic [7:0] IDX_EXT_WINDOW_MAP = 8'h55;
   localparam logic [7:0] IDX_DOWNSTREAM_CTRL = 8'h56;
   localparam logic [7:0] IDX_UPSTREAM_CTRL = 8'h57;
   localparam int ADDR_LSB = 2;

   // ***************************************************************
   // field positions and reset values
   // ***************************************************************
   localparam int DS_SUB_EN_BIT = 0;
   localparam int DS_NEG_EN_BIT = 1;
   localparam int DS_SUB_SLOW_BIT = 2;
   localparam int US_SUB_EN_BIT = 0;
   localparam int US_SUB_SLOW_BIT = 1;
   localparam logic [1:0] EXT_WINDOW_ENABLE_RST = 2'h0;
   localparam logic [1:0] EXT_WINDOW_MAP_RST = 2'h0;
   localparam logic [2:0] DOWNSTREAM_CTRL_RST = 3'h6;
   localparam logic [1:0] UPSTREAM_CTRL_RST = 2'h0;
   localparam logic [31:0] WIN_REG_RST = 32'h0000_0000;
   localparam logic [31:0] MEM_LIMIT_FILL = 32'h0000_0FFC;
   localparam logic [31:0] MEM_BASE_MASK = 32'hFFFF_F003;
   localparam logic [31:0] IO_BASE_MASK = 32'hFFFF_FFFC;
   localparam logic [1:0] WTYPE_MEM_NONPREF = 2'h0;
   localparam logic [1:0] WTYPE_MEM_PREF = 2'h1;

   // ***************************************************************
   // claim timing, in clocks after the frame starts
   // ***************************************************************
   localparam logic [2:0] SLOT_NORMAL = 3'h3;
   localparam logic [2:0] SLOT_SLOW = 3'h4;

   // subtractive claim sequencer states
   typedef enum logic [1:0] {
      BWDC_IDLE = 2'b01,
      BWDC_WAIT = 2'b10
   } bwdc_state_t;

   // one bus transaction as seen by the decoder
   typedef struct packed {
      logic start;
      logic io;
      logic [31:0] addr;
   } bwdc_txn_t;

   // claim answers for one bus
   typedef struct packed {
      logic pos_claim;
      logic sub_claim;
   } bwdc_claim_t;

endpackage

/* File: logic/bwdc_top.sv */
// Our own choice: the AHB-Lite register port.
module bwdc_top #(
   parameter logic [1:0] UP_CTRL_RESET = bwdc_pkg::UPSTREAM_CTRL_RST,
   parameter logic [6:0] CLASS_CODE_UPPER = 7'h02 // arbitrary value
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // upstream bus cycles
   input wire bwdc_pkg::bwdc_txn_t up_txn,
   input wire logic up_claimed_other,
   output bwdc_pkg::bwdc_claim_t up_claim,
   // downstream bus cycles
   input wire bwdc_pkg::bwdc_txn_t dn_txn,
   input wire logic dn_claimed_other,
   output bwdc_pkg::bwdc_claim_t dn_claim,
   // status
   output logic class_sub_flag
);

   // ***************************************************************
   // functions
   // ***************************************************************

   // window hit test shared by both buses and both windows
   function automatic logic win_hit(input logic [31:0] base, input logic [31:0] limit,
                                    input logic [31:0] addr, input logic io);
      logic [31:0] lo;
      logic [31:0] hi;
      logic win_io;
      lo = base & bwdc_pkg::IO_BASE_MASK;
      hi = limit | 32'h0000_0003;
      win_io = limit[1];
      if (!win_io) begin
         lo = base & bwdc_pkg::MEM_BASE_MASK & bwdc_pkg::IO_BASE_MASK;
         hi = limit | bwdc_pkg::MEM_LIMIT_FILL | 32'h0000_0003;
      end
      win_hit = (io == win_io) && (addr >= lo) && (addr <= hi);
   endfunction

   // claim slot picked by the speed bit
   function automatic logic [2:0] claim_slot(input logic slow);
      claim_slot = slow ? bwdc_pkg::SLOT_SLOW : bwdc_pkg::SLOT_NORMAL;
   endfunction

   // ***************************************************************
   // registers
   // ***************************************************************
   logic [1:0] win_en_reg;
   logic [1:0] win_map_reg;
   logic [2:0] dn_ctrl_reg;
   logic [1:0] up_ctrl_reg;
   logic [31:0] win_base_reg [2];
   logic [31:0] win_limit_reg [2];

   // bus slave state
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] idx_reg;
   logic [31:0] rd_next;
   logic [7:0] acc_idx;
   logic acc_take;

   assign acc_take = hsel && hready && htrans[1];
   assign acc_idx = haddr[bwdc_pkg::ADDR_LSB +: 8];

   // ***************************************************************
   // ahb-lite slave
   // ***************************************************************

   // capture the address phase; reads get one wait state so the read
   // always sees a write that finished in the cycle before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         idx_reg <= 8'h00;
      end else if (hreadyout) begin
         wr_pend_reg <= acc_take && hwrite;
         rd_pend_reg <= acc_take && !hwrite;
         idx_reg <= (haddr[31:10] == 22'h000000) ? acc_idx : 8'hFF;
      end else begin
         rd_pend_reg <= 1'b0;
      end
   end

   // wait flag: high for exactly the first data cycle of a read
   logic rd_wait_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_reg <= 1'b0;
      end else begin
         rd_wait_reg <= hreadyout && acc_take && !hwrite;
      end
   end

   assign hreadyout = !rd_wait_reg;
   assign hresp = 1'b0;

   // read mux; unmapped offsets read as zero
   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (idx_reg)
         bwdc_pkg::IDX_CLASS_CODE: rd_next = {24'h000000, CLASS_CODE_UPPER, up_ctrl_reg[0]};
         bwdc_pkg::IDX_WIN0_BASE: rd_next = win_base_reg[0];
         bwdc_pkg::IDX_WIN0_LIMIT: rd_next = win_limit_reg[0];
         bwdc_pkg::IDX_WIN1_BASE: rd_next = win_base_reg[1];
         bwdc_pkg::IDX_WIN1_LIMIT: rd_next = win_limit_reg[1];
         bwdc_pkg::IDX_EXT_WINDOW_ENABLE: rd_next = {30'h0, win_en_reg};
         bwdc_pkg::IDX_EXT_WINDOW_MAP: rd_next = {30'h0, win_map_reg};
         bwdc_pkg::IDX_DOWNSTREAM_CTRL: rd_next = {29'h0, dn_ctrl_reg};
         bwdc_pkg::IDX_UPSTREAM_CTRL: rd_next = {30'h0, up_ctrl_reg};
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // read data register, loaded during the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         hrdata <= rd_next;
      end
   end

   // decode control writes; reserved bits are never stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_en_reg <= bwdc_pkg::EXT_WINDOW_ENABLE_RST;
         win_map_reg <= bwdc_pkg::EXT_WINDOW_MAP_RST;
         dn_ctrl_reg <= bwdc_pkg::DOWNSTREAM_CTRL_RST;
         up_ctrl_reg <= UP_CTRL_RESET;
      end else if (wr_pend_reg) begin
         if (idx_reg == bwdc_pkg::IDX_EXT_WINDOW_ENABLE) begin
            win_en_reg <= hwdata[1:0];
         end
         if (idx_reg == bwdc_pkg::IDX_EXT_WINDOW_MAP) begin
            win_map_reg <= hwdata[1:0];
         end
         if (idx_reg == bwdc_pkg::IDX_DOWNSTREAM_CTRL) begin
            dn_ctrl_reg <= hwdata[2:0];
         end
         if (idx_reg == bwdc_pkg::IDX_UPSTREAM_CTRL) begin
            up_ctrl_reg <= hwdata[1:0];
         end
      end
   end

   // window base and limit writes; base low bits read as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_base_reg[0] <= bwdc_pkg::WIN_REG_RST;
         win_base_reg[1] <= bwdc_pkg::WIN_REG_RST;
         win_limit_reg[0] <= bwdc_pkg::WIN_REG_RST;
         win_limit_reg[1] <= bwdc_pkg::WIN_REG_RST;
      end else if (wr_pend_reg) begin
         if (idx_reg == bwdc_pkg::IDX_WIN0_BASE) begin
            win_base_reg[0] <= hwdata & bwdc_pkg::IO_BASE_MASK;
         end
         if (idx_reg == bwdc_pkg::IDX_WIN1_BASE) begin
            win_base_reg[1] <= hwdata & bwdc_pkg::IO_BASE_MASK;
         end
         if (idx_reg == bwdc_pkg::IDX_WIN0_LIMIT) begin
            win_limit_reg[0] <= hwdata;
         end
         if (idx_reg == bwdc_pkg::IDX_WIN1_LIMIT) begin
            win_limit_reg[1] <= hwdata;
         end
      end
   end

   assign class_sub_flag = up_ctrl_reg[bwdc_pkg::US_SUB_EN_BIT];

   // ***************************************************************
   // positive and negative decode
   // ***************************************************************
   logic [1:0] up_hit;
   logic [1:0] dn_hit;
   logic up_pos;
   logic dn_in_down_win;
   logic dn_in_excl_win;
   logic dn_pos;
   logic dn_neg_en;

   // per-window hits, gated by the enable bits
   always_comb begin
      for (int w = 0; w < 2; w++) begin
         up_hit[w] = win_en_reg[w] && win_hit(win_base_reg[w], win_limit_reg[w],
                                             up_txn.addr, up_txn.io);
         dn_hit[w] = win_en_reg[w] && win_hit(win_base_reg[w], win_limit_reg[w],
                                             dn_txn.addr, dn_txn.io);
      end
   end

   assign dn_neg_en = dn_ctrl_reg[bwdc_pkg::DS_NEG_EN_BIT];
   // upstream side claims only included windows
   assign up_pos = |(up_hit & ~win_map_reg);
   // downstream views of the same windows
   assign dn_in_down_win = |(dn_hit & ~win_map_reg);
   assign dn_in_excl_win = |(dn_hit & win_map_reg);
   // never send up what the upstream side would send down
   assign dn_pos = !dn_in_down_win && (dn_neg_en || dn_in_excl_win);

   // ***************************************************************
   // claim sequencers
   // ***************************************************************
   bwdc_pkg::bwdc_state_t up_state_reg;
   bwdc_pkg::bwdc_state_t dn_state_reg;
   logic [2:0] up_cnt_reg;
   logic [2:0] dn_cnt_reg;
   logic [2:0] up_slot_reg;
   logic [2:0] dn_slot_reg;

   // upstream: positive claim right after the frame start, else
   // subtractive claim at the chosen slot if nobody else answered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_state_reg <= bwdc_pkg::BWDC_IDLE;
         up_cnt_reg <= 3'h0;
         up_slot_reg <= bwdc_pkg::SLOT_NORMAL;
         up_claim <= '0;
      end else begin
         up_claim <= '0;
         unique case (up_state_reg)
            bwdc_pkg::BWDC_IDLE: begin
               if (up_txn.start) begin
                  if (up_pos) begin
                     up_claim.pos_claim <= 1'b1;
                  end else if (up_ctrl_reg[bwdc_pkg::US_SUB_EN_BIT]) begin
                     up_state_reg <= bwdc_pkg::BWDC_WAIT;
                     // the start cycle is cycle 0 and the claim is registered, so count from 2
                     up_cnt_reg <= 3'h2;
                     up_slot_reg <= claim_slot(up_ctrl_reg[bwdc_pkg::US_SUB_SLOW_BIT]);
                  end
               end
            end
            bwdc_pkg::BWDC_WAIT: begin
               // another agent answering ends the wait without a claim
               if (up_claimed_other) begin
                  up_state_reg <= bwdc_pkg::BWDC_IDLE;
               end else if (up_cnt_reg == up_slot_reg) begin
                  up_claim.sub_claim <= 1'b1;
                  up_state_reg <= bwdc_pkg::BWDC_IDLE;
               end else begin
                  up_cnt_reg <= up_cnt_reg + 3'h1;
               end
            end
         endcase
      end
   end

   // downstream: same shape; negative decode claims at once, the
   // subtractive path waits for its slot
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dn_state_reg <= bwdc_pkg::BWDC_IDLE;
         dn_cnt_reg <= 3'h0;
         dn_slot_reg <= bwdc_pkg::SLOT_SLOW;
         dn_claim <= '0;
      end else begin
         dn_claim <= '0;
         unique case (dn_state_reg)
            bwdc_pkg::BWDC_IDLE: begin
               if (dn_txn.start) begin
                  if (dn_pos) begin
                     dn_claim.pos_claim <= 1'b1;
                  end else if (dn_ctrl_reg[bwdc_pkg::DS_SUB_EN_BIT] && !dn_in_down_win) begin
                     dn_state_reg <= bwdc_pkg::BWDC_WAIT;
                     dn_cnt_reg <= 3'h2; // claim lands in cycle slot after the start
                     dn_slot_reg <= claim_slot(dn_ctrl_reg[bwdc_pkg::DS_SUB_SLOW_BIT]);
                  end
               end
            end
            bwdc_pkg::BWDC_WAIT: begin
               if (dn_claimed_other) begin
                  dn_state_reg <= bwdc_pkg::BWDC_IDLE;
               end else if (dn_cnt_reg == dn_slot_reg) begin
                  dn_claim.sub_claim <= 1'b1;
                  dn_state_reg <= bwdc_pkg::BWDC_IDLE;
               end else begin
                  dn_cnt_reg <= dn_cnt_reg + 3'h1;
               end
            end
         endcase
      end
   end

endmodule

/* File: sim/bwdc_agent.sv */
module bwdc_agent (
   // clock
   input wire logic hclk,
   // cycle offered to the bridge
   output bwdc_pkg::bwdc_txn_t txn,
   output logic claimed_other,
   // bridge answer
   input wire bwdc_pkg::bwdc_claim_t claim
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      txn = '0;
      claimed_other = 1'b0;
   end
   // ****
   // one frame: start pulse, optional foreign claim, claim watch
   // ****
   task automatic frame(input logic [31:0] a, input logic io, input int oth,
                        output int pos_n, output int sub_n);
      pos_n = 0;
      sub_n = 0;
      @(posedge hclk);
      txn <= '{start: 1'b1, io: io, addr: a};
      @(posedge hclk);
      // released lines show the inverse so a late sample cannot match by luck
      txn <= '{start: 1'b0, io: ~io, addr: ~a};
      for (int n = 1; n <= 8; n++) begin
         if (n == oth) claimed_other <= 1'b1;
         @(posedge hclk);
         if (claim.pos_claim === 1'b1 && pos_n == 0) pos_n = n;
         if (claim.sub_claim === 1'b1 && sub_n == 0) sub_n = n;
      end
      claimed_other <= 1'b0;
   endtask
endmodule

/* File: sim/bwdc_chk.sv */
module bwdc_chk (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // both buses
   input wire bwdc_pkg::bwdc_txn_t up_txn,
   input wire logic up_claimed_other,
   input wire bwdc_pkg::bwdc_claim_t up_claim,
   input wire bwdc_pkg::bwdc_txn_t dn_txn,
   input wire bwdc_pkg::bwdc_claim_t dn_claim,
   input wire logic class_sub_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ****
   // shadow of the controls, rebuilt from bus writes
   // ****
   logic wr_pend;
   logic [7:0] wr_idx;
   logic [1:0] en_r;
   logic [1:0] up_r;
   logic [2:0] dn_r;
   // address phase capture; writes never wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite && (haddr[31:10] == 22'h0);
         wr_idx <= haddr[9:2];
      end
   end
   // one process for all three keeps the helper small
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_r <= bwdc_pkg::EXT_WINDOW_ENABLE_RST;
         up_r <= bwdc_pkg::UPSTREAM_CTRL_RST;
         dn_r <= bwdc_pkg::DOWNSTREAM_CTRL_RST;
      end else if (wr_pend && hready) begin
         if (wr_idx == bwdc_pkg::IDX_EXT_WINDOW_ENABLE) en_r <= hwdata[1:0];
         if (wr_idx == bwdc_pkg::IDX_UPSTREAM_CTRL) up_r <= hwdata[1:0];
         if (wr_idx == bwdc_pkg::IDX_DOWNSTREAM_CTRL) dn_r <= hwdata[2:0];
      end
   end
   a_class_alias: assert property ($stable(up_r[0]) [*2] |-> class_sub_flag == up_r[0])
      else $error("class flag differs");
   a_up_sub_off: assert property (up_claim.sub_claim |-> up_r[0])
      else $error("up sub claim while off");
   a_dn_sub_off: assert property (dn_claim.sub_claim |-> dn_r[0])
      else $error("dn sub claim while off");
   a_up_sub_slot: assert property (up_claim.sub_claim |->
      (up_r[1] ? $past(up_txn.start, 4) : $past(up_txn.start, 3)))
      else $error("up sub slot");
   a_dn_sub_slot: assert property (dn_claim.sub_claim |->
      (dn_r[2] ? $past(dn_txn.start, 4) : $past(dn_txn.start, 3)))
      else $error("dn sub slot");
   a_up_pos_en: assert property (up_claim.pos_claim |-> en_r != 2'h0 && $past(up_txn.start))
      else $error("up pos claim");
   a_sub_cancel: assert property (up_claim.sub_claim |-> !$past(up_claimed_other))
      else $error("claimed cycle taken");
   a_dn_pos_why: assert property (dn_claim.pos_claim |-> dn_r[1] || en_r != 2'h0)
      else $error("dn pos claim");
   a_dn_pos_time: assert property (dn_claim.pos_claim |-> $past(dn_txn.start))
      else $error("dn pos timing");
endmodule

bind bwdc_top bwdc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .up_txn, .up_claimed_other, .up_claim, .dn_txn, .dn_claim, .class_sub_flag);

/* File: sim/tb.sv */
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // signals, design and both bus agents
   // ****
   localparam logic [6:0] CCU = 7'h2A; // arbitrary value
   localparam logic [31:0] A_CC = 32'h24, A_B0 = 32'h110, A_L0 = 32'h120, A_B1 = 32'h130;
   localparam logic [31:0] A_L1 = 32'h140, A_EN = 32'h150, A_MAP = 32'h154;
   localparam logic [31:0] A_DN = 32'h158, A_UP = 32'h15C;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, class_sub_flag, up_oth, dn_oth;
   logic [31:0] hrdata;
   bwdc_pkg::bwdc_txn_t up_txn, dn_txn;
   bwdc_pkg::bwdc_claim_t up_claim, dn_claim;
   int err_count = 0;
   int checked = 0;
   always #5 hclk = ~hclk;
   bwdc_top #(.CLASS_CODE_UPPER(CCU)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .up_txn,
      .up_claimed_other(up_oth), .up_claim, .dn_txn, .dn_claimed_other(dn_oth), .dn_claim,
      .class_sub_flag);
   bwdc_agent up_ag (.hclk, .txn(up_txn), .claimed_other(up_oth), .claim(up_claim));
   bwdc_agent dn_ag (.hclk, .txn(dn_txn), .claimed_other(dn_oth), .claim(dn_claim));
   // one single transfer; waits on hready, only the watchdog ends a hang
   task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [31:0] a, exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      `CHK(x, exp)
      `CHK(hresp, 1'b0)
   endtask
   // one frame on either bus, then compare claim cycles (0 = none)
   task automatic fr(input logic dn, input logic [31:0] a, input logic io,
                     input int oth, ep, es);
      int p, s;
      if (dn) dn_ag.frame(a, io, oth, p, s);
      else up_ag.frame(a, io, oth, p, s);
      `CHK(p, ep)
      `CHK(s, es)
   endtask
   // ****
   // scenarios
   // ****
   task automatic s_reset();
      rd(A_EN, 32'h0);
      rd(A_MAP, 32'h0);
      rd(A_DN, 32'h6);
      rd(A_UP, 32'h0);
      rd(A_CC, {24'h0, CCU, 1'b0});
   endtask
   // all ones written, only the defined bits come back
   task automatic s_regs();
      logic [31:0] ra[4] = '{A_EN, A_MAP, A_DN, A_UP};
      logic [31:0] rm[4] = '{32'h3, 32'h3, 32'h7, 32'h3};
      for (int i = 0; i < 4; i++) wr(ra[i], 32'hFFFF_FFFF);
      for (int i = 0; i < 4; i++) rd(ra[i], rm[i]);
      rd(A_CC, {24'h0, CCU, 1'b1});
      `CHK(class_sub_flag, 1'b1)
      wr(32'h200, 32'hFFFF_FFFF);
      rd(32'h200, 32'h0);
      for (int i = 0; i < 4; i++) wr(ra[i], 32'h0);
   endtask
   // window 0 memory, window 1 one I/O doubleword
   task automatic s_window();
      wr(A_B0, 32'h0001_0000);
      wr(A_L0, 32'h0001_0001);
      wr(A_B1, 32'h0000_2000);
      wr(A_L1, 32'h0000_2002);
      wr(A_DN, 32'h2);
      fr(0, 32'h0001_0000, 0, 0, 0, 0);
      wr(A_EN, 32'h3);
      fr(0, 32'h0001_0FFC, 0, 0, 1, 0);
      wr(A_L0, 32'h0001_0000);
      fr(0, 32'h0001_0000, 0, 0, 1, 0);
      fr(0, 32'h0001_1000, 0, 0, 0, 0);
      fr(0, 32'h0001_0000, 1, 0, 0, 0);
      fr(0, 32'h0000_2000, 1, 0, 1, 0);
      fr(0, 32'h0000_2004, 1, 0, 0, 0);
      fr(1, 32'h0001_0000, 0, 0, 0, 0);
      fr(1, 32'h0002_0000, 0, 0, 1, 0);
      wr(A_MAP, 32'h1);
      fr(0, 32'h0001_0000, 0, 0, 0, 0);
      wr(A_DN, 32'h0);
      fr(1, 32'h0001_0000, 0, 0, 1, 0);
      fr(1, 32'h0002_0000, 0, 0, 0, 0);
      wr(A_EN, 32'h2);
      fr(1, 32'h0001_0000, 0, 0, 0, 0);
   endtask
   // only the bridge decodes subtractively on each bus
   task automatic s_sub();
      wr(A_EN, 32'h0);
      wr(A_UP, 32'h1);
      fr(0, 32'h0003_0000, 0, 0, 0, bwdc_pkg::SLOT_NORMAL);
      fr(0, 32'h0003_0000, 0, 2, 0, 0);
      wr(A_UP, 32'h3);
      fr(0, 32'h0003_0000, 0, 0, 0, bwdc_pkg::SLOT_SLOW);
      wr(A_UP, 32'h2);
      fr(0, 32'h0003_0000, 0, 0, 0, 0);
      `CHK(class_sub_flag, 1'b0)
      wr(A_DN, 32'h5);
      fr(1, 32'h0003_0000, 0, 0, 0, bwdc_pkg::SLOT_SLOW);
      wr(A_DN, 32'h1);
      fr(1, 32'h0003_0000, 0, 0, 0, bwdc_pkg::SLOT_NORMAL);
      wr(A_DN, 32'h4);
      fr(1, 32'h0003_0000, 0, 0, 0, 0);
   endtask
   task automatic final_report();
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset();
      s_regs();
      s_window();
      s_sub();
      final_report();
   end
   // watchdog, far beyond the roughly 340 cycles the tests need
   initial begin
      #100000;
      err_count++;
      final_report();
   end
endmodule
